// ===== hdl/sled_defs.svh
// status indicator and teach control: offsets, fields, reset values, timing counts
// assumes a 100 MHz clock and an AXI4-Lite register bus with 32-bit data
`ifndef SLED_DEFS_SVH
`define SLED_DEFS_SVH

// --------------------
// register byte offsets
// --------------------
`define SLED_OFS_CTRL    8'h00
`define SLED_OFS_COLOR   8'h04
`define SLED_OFS_STATUS  8'h08
`define SLED_OFS_IRQSTAT 8'h0C
`define SLED_OFS_IRQMASK 8'h10
`define SLED_OFS_TEACHPOS 8'h14

// --------------------
// fields and reset values
// --------------------
`define SLED_CTRL_MODE_LSB  0
`define SLED_CTRL_TEACH_BIT 4
`define SLED_CTRL_LOC_BIT   5
`define SLED_CTRL_ACT_BIT   6
`define SLED_CTRL_RESET     32'h0000_0001
`define SLED_COLOR_RESET    32'h0000_0204
`define SLED_IRQ_TEACHDONE  0
`define SLED_IRQ_TEACHERR   1
`define SLED_IRQ_STATUS     2

// --------------------
// timing in cycles of the 100 MHz clock
// --------------------
`define SLED_HOLD_CYC      500_000_000
`define SLED_FLASH_CYC     10_000_000
`define SLED_BLINK_CYC     50_000_000
`define SLED_GAP_CYC       2_000_000
`define SLED_LOC_CYC       100_000_000
`define SLED_TEACH_TO_CYC  1_000_000_000

`endif

// ===== hdl/sled_pkg.sv
// status indicator and teach control: shared types
// assumes the constants header is included by users alongside
package sled_pkg;

    // colour choice for the RGB indicator
    typedef enum logic [2:0] {
        SLED_OFF    = 3'h0,
        SLED_WHITE  = 3'h1,
        SLED_GREEN  = 3'h2,
        SLED_BLUE   = 3'h3,
        SLED_YELLOW = 3'h4,
        SLED_ORANGE = 3'h5,
        SLED_RED    = 3'h6
    } sled_color_t;

    // indicator mode
    typedef enum logic [2:0] {
        SLED_M_VALVE = 3'h0,
        SLED_M_WARN  = 3'h1,
        SLED_M_NAMUR = 3'h2,
        SLED_M_FIXED = 3'h3,
        SLED_M_DARK  = 3'h4
    } sled_mode_t;

    // active device status conditions
    typedef struct packed {
        logic failure;
        logic funcCheck;
        logic outOfSpec;
        logic maint;
        logic diagActive;
    } sled_status_t;

    // RGB drive
    typedef struct packed {
        logic red;
        logic green;
        logic blue;
    } sled_rgb_t;

endpackage : sled_pkg

// ===== hdl/sled_top.sv
// status indicator and teach control: one block with an AXI4-Lite slave
// assumes one 100 MHz clock, synchronous inputs and synchronous active-low reset
//
// Added by the designer: the register offsets and register access over AXI4-Lite.
`timescale 1ns/1ps
`default_nettype none
`include "sled_defs.svh"

module sled_top
    import sled_pkg::*;
#(
    parameter int unsigned HOLD_CYC    = `SLED_HOLD_CYC,
    parameter int unsigned FLASH_CYC   = `SLED_FLASH_CYC,
    parameter int unsigned BLINK_CYC   = `SLED_BLINK_CYC,
    parameter int unsigned GAP_CYC     = `SLED_GAP_CYC,
    parameter int unsigned LOC_CYC     = `SLED_LOC_CYC,
    parameter int unsigned TEACH_TO_CYC = `SLED_TEACH_TO_CYC
)(
    // clock and reset
    input  wire logic         clk,
    input  wire logic         rst_n,
    // AXI4-Lite slave
    input  wire logic [7:0]   s_axi_awaddr,
    input  wire logic         s_axi_awvalid,
    output logic              s_axi_awready,
    input  wire logic [31:0]  s_axi_wdata,
    input  wire logic [3:0]   s_axi_wstrb,
    input  wire logic         s_axi_wvalid,
    output logic              s_axi_wready,
    output logic [1:0]        s_axi_bresp,
    output logic              s_axi_bvalid,
    input  wire logic         s_axi_bready,
    input  wire logic [7:0]   s_axi_araddr,
    input  wire logic         s_axi_arvalid,
    output logic              s_axi_arready,
    output logic [31:0]       s_axi_rdata,
    output logic [1:0]        s_axi_rresp,
    output logic              s_axi_rvalid,
    input  wire logic         s_axi_rready,
    // device side
    input  wire logic         teachButton,
    input  wire sled_status_t devStatus,
    input  wire logic         posOpen,
    input  wire logic         posClosed,
    input  wire logic [15:0]  posValue,
    input  wire logic         atTop,
    input  wire logic         atHome,
    input  wire logic         cmdActuate,
    // outputs
    output sled_rgb_t         statusRgb,
    output logic              teachLed,
    output logic              pilotValve,
    output logic              irq
);

    // --------------------
    // helpers
    // --------------------
    function automatic sled_rgb_t toRgb(input logic [2:0] c);
        unique case (c)
            3'h1:    toRgb = 3'b111;
            3'h2:    toRgb = 3'b010;
            3'h3:    toRgb = 3'b001;
            3'h4:    toRgb = 3'b110;
            3'h5:    toRgb = 3'b110; // orange; needs PWM on green for a true tint
            3'h6:    toRgb = 3'b100;
            default: toRgb = 3'b000;
        endcase
    endfunction : toRgb

    // --------------------
    // registers
    // --------------------
    logic [31:0] ctrl_q, color_q;
    logic [2:0]  irqStat_q, irqMask_q;
    logic [15:0] posBottom_q, posTop_q;
    logic        teachErr_q, teachRun;
    logic        awHave_q, wHave_q;
    logic [7:0]  awAddr_q;
    logic [31:0] wData_q;
    logic        teachDone, statusRise, paramTeach, teachErrSet;
    sled_status_t statusPrev_q;

    wire doWrite = awHave_q && wHave_q && !s_axi_bvalid;

    // write address and data taken in either order
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            awHave_q <= 1'b0;
            wHave_q  <= 1'b0;
            awAddr_q <= 8'h00;
            wData_q  <= 32'h0000_0000;
            s_axi_bvalid <= 1'b0;
        end
        else
        begin
            if (s_axi_awvalid && s_axi_awready)
            begin
                awHave_q <= 1'b1;
                awAddr_q <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready)
            begin
                wHave_q <= 1'b1;
                wData_q <= s_axi_wdata;
            end
            if (doWrite)
            begin
                awHave_q     <= 1'b0;
                wHave_q      <= 1'b0;
                s_axi_bvalid <= 1'b1;
            end
            else if (s_axi_bready)
                s_axi_bvalid <= 1'b0;
        end
    end
    assign s_axi_awready = !awHave_q;
    assign s_axi_wready  = !wHave_q;
    assign s_axi_bresp   = 2'b00;
    assign paramTeach    = doWrite && awAddr_q == `SLED_OFS_CTRL && wData_q[`SLED_CTRL_TEACH_BIT];

    // software registers; wstrb ignored, full-word writes expected
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            ctrl_q    <= `SLED_CTRL_RESET;
            color_q   <= `SLED_COLOR_RESET;
            irqMask_q <= 3'h0;
        end
        else if (doWrite)
        begin
            unique case (awAddr_q)
                `SLED_OFS_CTRL:    ctrl_q    <= wData_q & 32'h0000_0067;
                `SLED_OFS_COLOR:   color_q   <= wData_q & 32'h0000_0777;
                `SLED_OFS_IRQMASK: irqMask_q <= wData_q[2:0];
                default: ;
            endcase
        end
    end

    // sticky events, set wins over write-one-to-clear
    assign statusRise = |(devStatus & ~statusPrev_q);
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            irqStat_q    <= 3'h0;
            statusPrev_q <= '0;
            irq          <= 1'b0;
        end
        else
        begin
            statusPrev_q <= devStatus;
            irqStat_q <= (irqStat_q & ~((doWrite && awAddr_q == `SLED_OFS_IRQSTAT) ? wData_q[2:0] : 3'h0))
                       | {statusRise, teachErrSet, teachDone};
            irq <= |(irqStat_q & irqMask_q);
        end
    end

    // read channel, one cycle latency
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= 32'h0000_0000;
            s_axi_rresp  <= 2'b00;
        end
        else if (s_axi_arvalid && s_axi_arready)
        begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp  <= 2'b00;
            unique case (s_axi_araddr)
                `SLED_OFS_CTRL:     s_axi_rdata <= ctrl_q;
                `SLED_OFS_COLOR:    s_axi_rdata <= color_q;
                `SLED_OFS_STATUS:   s_axi_rdata <= {24'h0, 1'b0, pilotValve, teachErr_q, teachRun, 4'h0} | 32'(devStatus);
                `SLED_OFS_IRQSTAT:  s_axi_rdata <= {29'h0, irqStat_q};
                `SLED_OFS_IRQMASK:  s_axi_rdata <= {29'h0, irqMask_q};
                `SLED_OFS_TEACHPOS: s_axi_rdata <= {posTop_q, posBottom_q};
                default:
                begin
                    s_axi_rdata <= 32'h0000_0000;
                    s_axi_rresp <= 2'b10; // slverr for unmapped
                end
            endcase
        end
        else if (s_axi_rready)
            s_axi_rvalid <= 1'b0;
    end
    assign s_axi_arready = !s_axi_rvalid;

    // --------------------
    // button hold and teach sequencer
    // --------------------
    typedef enum logic [6:0] {
        T_IDLE   = 7'b0000001,
        T_ARMED  = 7'b0000010,
        T_BOTTOM = 7'b0000100,
        T_RISE   = 7'b0001000,
        T_TOP    = 7'b0010000,
        T_FALL   = 7'b0100000,
        T_HOME   = 7'b1000000
    } sled_teach_t;
    sled_teach_t tState_q;
    logic [31:0] tCnt_q;

    assign teachRun  = !(tState_q inside {T_IDLE, T_ARMED});
    assign teachDone = tState_q == T_HOME && atHome;

    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            tState_q    <= T_IDLE;
            tCnt_q      <= 32'h0;
            posBottom_q <= 16'h0;
            posTop_q    <= 16'h0;
            teachErr_q  <= 1'b0;
        end
        else
        begin
            tCnt_q <= tCnt_q + 32'h1;
            unique case (tState_q)
                T_IDLE:
                    if (paramTeach)
                    begin
                        tState_q <= T_BOTTOM;
                        tCnt_q   <= 32'h0;
                    end
                    else if (!teachButton)
                        tCnt_q <= 32'h0;
                    else if (tCnt_q == HOLD_CYC - 1) // no re-arm until released
                    begin
                        tState_q <= T_ARMED;
                        tCnt_q   <= 32'h0;
                    end
                T_ARMED:
                    if (!teachButton)
                    begin
                        tState_q <= T_BOTTOM;
                        tCnt_q   <= 32'h0;
                    end
                    else if (tCnt_q >= HOLD_CYC - 1)
                        tState_q <= T_IDLE; // held too long, no auto teach
                T_BOTTOM:
                begin
                    posBottom_q <= posValue;
                    teachErr_q  <= 1'b0;
                    tState_q    <= T_RISE;
                    tCnt_q      <= 32'h0;
                end
                T_RISE:
                    if (atTop)
                        tState_q <= T_TOP;
                    else if (tCnt_q >= TEACH_TO_CYC - 1)
                    begin
                        teachErr_q <= 1'b1;
                        tState_q   <= T_FALL;
                    end
                T_TOP:
                begin
                    posTop_q <= posValue;
                    tState_q <= T_FALL;
                    tCnt_q   <= 32'h0;
                end
                T_FALL:
                begin
                    tState_q <= T_HOME;
                    tCnt_q   <= 32'h0;
                end
                T_HOME:
                    if (atHome)
                        tState_q <= T_IDLE;
            endcase
        end
    end
    assign teachErrSet = tState_q == T_RISE && !atTop && tCnt_q >= TEACH_TO_CYC - 1;

    // pilot valve: teach owns it, interface commands locked out meanwhile
    always_ff @(posedge clk)
    begin
        if (!rst_n)
            pilotValve <= 1'b0;
        else if (teachRun)
            pilotValve <= tState_q inside {T_RISE, T_TOP};
        else
            pilotValve <= cmdActuate | ctrl_q[`SLED_CTRL_ACT_BIT];
    end

    // --------------------
    // flash timing
    // --------------------
    logic [31:0] fCnt_q, bCnt_q, lCnt_q;
    logic        flash_q, blink_q, locOn_q;
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            fCnt_q  <= 32'h0;
            bCnt_q  <= 32'h0;
            flash_q <= 1'b0;
            blink_q <= 1'b0;
        end
        else
        begin
            fCnt_q <= (fCnt_q >= FLASH_CYC - 1) ? 32'h0 : fCnt_q + 32'h1;
            bCnt_q <= (bCnt_q >= BLINK_CYC - 1) ? 32'h0 : bCnt_q + 32'h1;
            if (fCnt_q >= FLASH_CYC - 1)
                flash_q <= !flash_q;
            if (bCnt_q >= BLINK_CYC - 1)
                blink_q <= !blink_q;
        end
    end

    // localization window, retriggered by the control bit
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            lCnt_q  <= 32'h0;
            locOn_q <= 1'b0;
        end
        else if (doWrite && awAddr_q == `SLED_OFS_CTRL && wData_q[`SLED_CTRL_LOC_BIT])
        begin
            lCnt_q  <= 32'h0;
            locOn_q <= 1'b1;
        end
        else if (locOn_q)
        begin
            lCnt_q <= lCnt_q + 32'h1;
            if (lCnt_q >= LOC_CYC - 1)
                locOn_q <= 1'b0;
        end
    end

    // --------------------
    // colour selection
    // --------------------
    logic [2:0]  posColor, statColor;
    logic        anyWarn;
    logic        phaseA_q, gapOn_q;
    logic [31:0] gCnt_q;
    logic        warnFlash;
    always_comb
    begin
        posColor = posOpen ? color_q[2:0] : posClosed ? color_q[10:8] : color_q[6:4];
        anyWarn  = 1'b1;
        warnFlash = flash_q;
        // highest severity wins
        if (devStatus.failure)
            statColor = 3'h6;
        else if (devStatus.funcCheck)
            statColor = 3'h5;
        else if (devStatus.outOfSpec)
            statColor = 3'h4;
        else if (devStatus.maint)
        begin
            statColor = 3'h3;
            warnFlash = posClosed ? flash_q : blink_q; // blue blinks except when closed
        end
        else
        begin
            statColor = 3'h2;
            anyWarn   = 1'b0;
        end
    end

    // alternation with an off gap on each colour change
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            phaseA_q <= 1'b0;
            gapOn_q  <= 1'b0;
            gCnt_q   <= 32'h0;
        end
        else if (gapOn_q)
        begin
            gCnt_q <= gCnt_q + 32'h1;
            if (gCnt_q >= GAP_CYC - 1)
                gapOn_q <= 1'b0;
        end
        else if (warnFlash != phaseA_q)
        begin
            phaseA_q <= warnFlash;
            gapOn_q  <= anyWarn;
            gCnt_q   <= 32'h0;
        end
    end

    // final drive, registered
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            statusRgb <= 3'b000;
            teachLed  <= 1'b0;
        end
        else
        begin
            teachLed <= teachRun ? flash_q : teachErr_q || tState_q == T_ARMED && flash_q;
            if (locOn_q)
                statusRgb <= flash_q ? toRgb(statColor) : toRgb(posColor);
            else
            begin
                unique case (sled_mode_t'(ctrl_q[2:0]))
                    SLED_M_VALVE: statusRgb <= toRgb(posColor);
                    SLED_M_WARN:
                        statusRgb <= !anyWarn ? toRgb(posColor) : gapOn_q ? 3'b000
                                   : phaseA_q ? toRgb(statColor) : toRgb(posColor);
                    SLED_M_NAMUR: statusRgb <= toRgb(statColor);
                    SLED_M_FIXED: statusRgb <= toRgb(color_q[2:0]);
                    default:      statusRgb <= 3'b000;
                endcase
            end
        end
    end

endmodule : sled_top
`default_nettype wire

// ===== verification/sled_monitor.sv
// sled_monitor: bus handshake and teach checks on the sled_top ports
// assumes one clock domain, synchronous active-low reset, bound into sled_top
`timescale 1ns/1ps
`default_nettype none

module sled_monitor #(
    parameter int unsigned TEACH_TO_CYC = 50
)(
    // clock and reset
    input wire logic        clk,
    input wire logic        rst_n,
    // register bus
    input wire logic        s_axi_awvalid,
    input wire logic        s_axi_awready,
    input wire logic        s_axi_wvalid,
    input wire logic        s_axi_wready,
    input wire logic [1:0]  s_axi_bresp,
    input wire logic        s_axi_bvalid,
    input wire logic        s_axi_bready,
    input wire logic [7:0]  s_axi_araddr,
    input wire logic        s_axi_arvalid,
    input wire logic        s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0]  s_axi_rresp,
    input wire logic        s_axi_rvalid,
    input wire logic        s_axi_rready,
    // device side
    input wire logic        atTop,
    input wire logic        cmdActuate,
    input wire logic        pilotValve,
    input wire logic        irq
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    // --------------------
    // helper: cycles the pilot has waited for the top position
    // --------------------
    // an actuation command clears it, since then the pilot is not ours
    logic [31:0] waitCnt_q;
    always_ff @(posedge clk)
    begin
        if (!rst_n || !pilotValve || atTop || cmdActuate)
            waitCnt_q <= 32'h0;
        else
            waitCnt_q <= waitCnt_q + 32'h1;
    end

    // --------------------
    // assertions
    // --------------------
    wr_answer_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid)
        else $error("write answer missing");
    b_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
        else $error("write answer dropped early");
    b_okay_a: assert property (s_axi_bvalid |-> s_axi_bresp == 2'h0)
        else $error("write answer not okay");
    rd_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read answer missing");
    r_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read answer changed before taken");
    ar_block_a: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read address taken while answer pending");
    rd_unmapped_a: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr > 8'h17
        |=> s_axi_rresp == 2'h2 && s_axi_rdata == 32'h0)
        else $error("unmapped read not refused");
    pilot_top_a: assert property (pilotValve && atTop && !cmdActuate |-> ##[1:4] !pilotValve)
        else $error("pilot kept on at top");
    pilot_timeout_a: assert property (waitCnt_q <= TEACH_TO_CYC + 4)
        else $error("pilot wait exceeds timeout");

    // main scenarios reached
    teach_end_c: cover property ($fell(pilotValve) && !cmdActuate);
    irq_rise_c: cover property ($rose(irq));
    unmapped_c: cover property (s_axi_arvalid && s_axi_arready && s_axi_araddr > 8'h17);
endmodule : sled_monitor

bind sled_top sled_monitor #(.TEACH_TO_CYC(TEACH_TO_CYC)) sled_monitor_i (.clk, .rst_n, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .atTop,
    .cmdActuate, .pilotValve, .irq);

`default_nettype wire

// ===== verification/sled_top_test.sv
// sled_top_test: self-checking bench for the indicator and teach block
// assumes sled_top with short timing parameters and the bound monitor
`timescale 1ns/1ps
`default_nettype none

module sled_top_test;
    import sled_pkg::*;
    localparam int unsigned HOLD = 20;
    localparam int unsigned TMO  = 50;
    logic         clk, rst_n, teachButton, posOpen, posClosed, atTop, atHome, cmdActuate;
    logic         awValid, awReady, wValid, wReady, bValid, bReady, arValid, arReady, rValid, rReady;
    logic         teachLed, pilotValve, irq;
    logic [7:0]   awAddr, arAddr;
    logic [31:0]  wData, rData;
    logic [15:0]  posValue;
    logic [1:0]   bResp, rResp;
    sled_status_t devStatus;
    sled_rgb_t    statusRgb;
    int           failures, compares;

    sled_top #(.HOLD_CYC(HOLD), .FLASH_CYC(4), .BLINK_CYC(8), .GAP_CYC(2), .LOC_CYC(16), .TEACH_TO_CYC(TMO))
    sled_top_i (.clk, .rst_n, .s_axi_awaddr(awAddr), .s_axi_awvalid(awValid), .s_axi_awready(awReady),
        .s_axi_wdata(wData), .s_axi_wstrb(4'hF), .s_axi_wvalid(wValid), .s_axi_wready(wReady),
        .s_axi_bresp(bResp), .s_axi_bvalid(bValid), .s_axi_bready(bReady), .s_axi_araddr(arAddr),
        .s_axi_arvalid(arValid), .s_axi_arready(arReady), .s_axi_rdata(rData), .s_axi_rresp(rResp),
        .s_axi_rvalid(rValid), .s_axi_rready(rReady), .teachButton, .devStatus, .posOpen, .posClosed,
        .posValue, .atTop, .atHome, .cmdActuate, .statusRgb, .teachLed, .pilotValve, .irq);

    // --------------------
    // shared tasks
    // --------------------
    task automatic complete_run();
        $display("compares %0d failures %0d", compares, failures);
        if (failures == 0 && compares > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : complete_run

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp)
        begin
            failures++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask : chk

    // a wait that runs out ends the run as a failure
    task automatic bound(input bit ok);
        if (!ok)
        begin
            failures++;
            complete_run();
        end
    endtask : bound

    task automatic waitOn(ref logic s, input logic v, input int lim, output int n);
        for (n = 0; n < lim && s !== v; n++)
            @(posedge clk);
        bound(s === v);
    endtask : waitOn

    // offers address and data together, drops each as it is taken
    task automatic axiWrite(input logic [7:0] a, input logic [31:0] d);
        bit done;
        done = 0;
        @(posedge clk);
        awAddr  <= a;
        wData   <= d;
        awValid <= 1'b1;
        wValid  <= 1'b1;
        bReady  <= 1'b1;
        for (int n = 0; n < 40 && !done; n++)
        begin
            @(posedge clk);
            if (awValid && awReady)
                awValid <= 1'b0;
            if (wValid && wReady)
                wValid <= 1'b0;
            done = bValid;
        end
        bReady <= 1'b0;
        bound(done);
    endtask : axiWrite

    task automatic rdChk(input logic [7:0] a, input logic [31:0] exp, input logic [31:0] m, input logic [1:0] er);
        bit done;
        done = 0;
        @(posedge clk);
        arAddr  <= a;
        arValid <= 1'b1;
        rReady  <= 1'b1;
        for (int n = 0; n < 40 && !done; n++)
        begin
            @(posedge clk);
            if (arValid && arReady)
                arValid <= 1'b0;
            done = rValid;
        end
        rReady <= 1'b0;
        bound(done);
        chk(rData & m, exp);
        chk(rResp, er);
    endtask : rdChk

    // notes every colour shown, and direct colour-to-colour changes
    task automatic sampleRgb(input int n, output logic [7:0] seen, output int jumps);
        logic [2:0] prev;
        seen  = 8'h00;
        jumps = 0;
        prev  = statusRgb;
        repeat (n)
        begin
            @(negedge clk);
            seen[statusRgb] = 1'b1;
            if (prev != 3'h0 && statusRgb != 3'h0 && statusRgb != prev)
                jumps++;
            prev = statusRgb;
        end
        @(posedge clk);
    endtask : sampleRgb

    function automatic logic [2:0] rgbOf(input int c);
        case (c)
            1: rgbOf = 3'h7;
            2: rgbOf = 3'h2;
            3: rgbOf = 3'h1;
            4, 5: rgbOf = 3'h6;
            6: rgbOf = 3'h4;
            default: rgbOf = 3'h0;
        endcase
    endfunction : rgbOf

    // --------------------
    // scenarios
    // --------------------
    task automatic t_regs();
        rdChk(8'h00, 32'h1, 32'h7F, 2'h0);
        rdChk(8'h04, 32'h204, 32'h777, 2'h0);
        rdChk(8'h40, 32'h0, 32'hFFFFFFFF, 2'h2);
        $display("t_regs done");
    endtask : t_regs

    task automatic t_valve();
        logic [7:0] seen;
        int         j;
        axiWrite(8'h00, 32'h0);
        for (int c = 0; c < 7; c++)
        begin
            axiWrite(8'h04, c | ((6 - c) << 4) | (((c + 3) % 7) << 8));
            posOpen <= 1'b1;
            sampleRgb(6, seen, j);
            chk(statusRgb, rgbOf(c));
            posOpen <= 1'b0;
            sampleRgb(6, seen, j);
            chk(statusRgb, rgbOf(6 - c));
            posClosed <= 1'b1;
            sampleRgb(6, seen, j);
            chk(statusRgb, rgbOf((c + 3) % 7));
            posClosed <= 1'b0;
        end
        axiWrite(8'h04, 32'h204);
        axiWrite(8'h00, 32'h4);
        sampleRgb(20, seen, j);
        chk(seen, 8'h01);
        $display("t_valve done");
    endtask : t_valve

    task automatic t_status();
        logic [7:0] seen;
        int         j;
        logic [2:0] code [5] = '{3'h4, 3'h6, 3'h6, 3'h1, 3'h2};
        posClosed <= 1'b1;
        axiWrite(8'h00, 32'h2);
        for (int k = 0; k < 5; k++)
        begin
            devStatus <= sled_status_t'(5'h1F >> k);
            sampleRgb(6, seen, j);
            sampleRgb(60, seen, j);
            chk(seen & 8'hFE, 8'h01 << code[k]);
        end
        axiWrite(8'h00, 32'h1);
        devStatus <= sled_status_t'(5'h11);
        sampleRgb(6, seen, j);
        sampleRgb(120, seen, j);
        chk(seen, 8'h15);
        chk(j, 0);
        devStatus <= sled_status_t'(5'h00);
        posClosed <= 1'b0;
        $display("t_status done");
    endtask : t_status

    task automatic t_teach();
        int n, tog, hi;
        axiWrite(8'h0C, 32'h7);
        axiWrite(8'h10, 32'h1);
        teachButton <= 1'b1;
        repeat (3 * HOLD) @(posedge clk);
        teachButton <= 1'b0;
        repeat (12) @(posedge clk);
        chk(pilotValve, 1'b0);
        teachButton <= 1'b1;
        waitOn(teachLed, 1'b1, HOLD + 20, n);
        chk(n >= HOLD - 2, 1'b1);
        teachButton <= 1'b0;
        waitOn(pilotValve, 1'b1, 20, n);
        posValue <= 16'hABCD;
        atTop <= 1'b1;
        waitOn(pilotValve, 1'b0, 10, n);
        cmdActuate <= 1'b1;
        tog = 0;
        hi  = 0;
        repeat (24)
        begin
            @(negedge clk);
            hi  += pilotValve;
            tog += teachLed;
        end
        chk(hi, 0);
        chk(tog > 0 && tog < 24, 1'b1);
        cmdActuate <= 1'b0;
        atTop      <= 1'b0;
        atHome     <= 1'b1;
        repeat (6) @(posedge clk);
        hi = 0;
        repeat (16)
        begin
            @(negedge clk);
            hi += teachLed;
        end
        chk(hi, 0);
        chk(irq, 1'b1);
        rdChk(8'h0C, 32'h1, 32'h1, 2'h0);
        rdChk(8'h14, 32'hABCD1234, 32'hFFFFFFFF, 2'h0);
        axiWrite(8'h0C, 32'h7);
        repeat (3) @(posedge clk);
        chk(irq, 1'b0);
        $display("t_teach done");
    endtask : t_teach

    task automatic t_teach_err();
        int n, hi;
        axiWrite(8'h10, 32'h2);
        axiWrite(8'h00, 32'h11);
        waitOn(pilotValve, 1'b1, 10, n);
        waitOn(pilotValve, 1'b0, TMO + 10, n);
        chk(n >= TMO - 4, 1'b1);
        repeat (4) @(posedge clk);
        hi = 0;
        repeat (16)
        begin
            @(negedge clk);
            hi += teachLed;
        end
        chk(hi, 16);
        chk(irq, 1'b1);
        axiWrite(8'h10, 32'h0);
        repeat (3) @(posedge clk);
        chk(irq, 1'b0);
        rdChk(8'h0C, 32'h2, 32'h2, 2'h0);
        axiWrite(8'h0C, 32'h7);
        $display("t_teach_err done");
    endtask : t_teach_err

    // --------------------
    // clock, reset and main sequence
    // --------------------
    initial
    begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    initial
    begin
        {rst_n, teachButton, posOpen, posClosed, atTop, atHome, cmdActuate} = 7'h0;
        {awValid, wValid, bReady, arValid, rReady} = 5'h0;
        {awAddr, arAddr, wData} = 48'h0;
        posValue  = 16'h1234;
        devStatus = sled_status_t'(5'h00);
        failures  = 0;
        compares  = 0;
        repeat (16) @(posedge clk);
        rst_n <= 1'b1;
        t_regs();
        t_valve();
        t_status();
        t_teach();
        t_teach_err();
        complete_run();
    end
endmodule : sled_top_test

`default_nettype wire
